// File: hdl/sr_edge.sv
// pin synchroniser with once-per-scan sampling and rising edge detect
`timescale 1ns/1ns
`default_nettype none
module sr_edge (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic pin,
	input  wire logic sample,
	output logic      level,
	output logic      rise
);
	logic sync1;
	logic sync2;
	logic next_level;
	logic next_rise;

	// edge is judged against the previous scan's sample
	always_comb begin
		next_level = level;
		next_rise = 1'b0;
		if (sample) begin
			next_level = sync2;
			next_rise = sync2 & ~level;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			level <= 1'b0;
			rise <= 1'b0;
		end else begin
			sync1 <= pin;
			sync2 <= sync1;
			level <= next_level;
			rise <= next_rise;
		end
	end
endmodule
`default_nettype wire

// File: hdl/sr_pkg.sv
// shared constants and types for the scan-driven byte shift register
package sr_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int NUM_BYTES = 4;
	localparam int SCAN_W = 16;

	// register byte offsets
	localparam logic [3:0] OFF_CTRL   = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_STORE  = 4'h8;
	localparam logic [3:0] OFF_SCAN   = 4'hC;

	// control field positions
	localparam int CTRL_BYTE_LSB = 0;
	localparam int CTRL_BYTE_MSB = 1;
	localparam int CTRL_SEL_LSB  = 2;
	localparam int CTRL_SEL_MSB  = 4;
	localparam int CTRL_RETAIN   = 5;
	localparam int CTRL_RUN      = 6;

	// status field positions
	localparam int STAT_BYTE_LSB = 0;
	localparam int STAT_BYTE_MSB = 7;
	localparam int STAT_OUT      = 8;

	// reset values
	localparam logic [6:0]        CTRL_RST  = 7'h40;
	localparam logic [SCAN_W-1:0] SCAN_RST  = 16'h0000;
	localparam logic [BYTE_W-1:0] BYTE_RST  = 8'h00;
	localparam logic [DATA_W-1:0] READ_IDLE = 32'h0000_0000;

	typedef struct packed {
		logic       run;
		logic       retain;
		logic [2:0] out_sel;
		logic [1:0] byte_idx;
	} sr_cfg_s;

	typedef struct packed {
		logic data;
		logic dir;
		logic strobe_rise;
		logic clear_rise;
		logic loss_rise;
	} sr_in_s;

endpackage

// File: hdl/sr_scan.sv
// scan tick divider: one-cycle enable every period+1 clocks while running
`timescale 1ns/1ns
`default_nettype none
module sr_scan (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      run,
	input  wire logic [sr_pkg::SCAN_W-1:0] period,
	output logic                           tick
);
	logic [sr_pkg::SCAN_W-1:0] count;
	logic [sr_pkg::SCAN_W-1:0] next_count;
	logic                      next_tick;

	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!run) begin
			next_count = sr_pkg::SCAN_RST;
		end else if (count >= period) begin
			next_count = sr_pkg::SCAN_RST;
			next_tick = 1'b1;
		end else begin
			next_count = count + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count <= sr_pkg::SCAN_RST;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// File: hdl/sr_top.sv
// eight-bit bidirectional shift register block with register port
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - a strobe rising edge caught at a scan sample samples data and shifts once unless clear rises in the same scan; falling edges ignored
// - direction low: data enters bottom_bit, bits move toward top_bit
// - direction high: data enters top_bit, bits move toward bottom_bit
// - clear rising edge zeroes all eight bits
// - output always shows one chosen bit, positions one to eight
// - storage is four bytes; a byte index picks the one used
// - without retention, power loss empties the register
// - with retention, all eight bits survive power loss
module sr_top (
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire logic                      data_pin,
	input  wire logic                      strobe_pin,
	input  wire logic                      dir_pin,
	input  wire logic                      clear_pin,
	input  wire logic                      power_lost_pin,
	input  wire logic [sr_pkg::ADDR_W-1:0] addr,
	input  wire logic [sr_pkg::DATA_W-1:0] wr_data,
	input  wire logic                      wr_en,
	input  wire logic                      rd_en,
	output logic      [sr_pkg::DATA_W-1:0] rd_data,
	output logic                           q_out
);
	sr_pkg::sr_cfg_s           cfg;
	sr_pkg::sr_cfg_s           next_cfg;
	logic [sr_pkg::SCAN_W-1:0] scan_period;
	logic [sr_pkg::SCAN_W-1:0] next_scan_period;
	logic [sr_pkg::BYTE_W-1:0] store [sr_pkg::NUM_BYTES];
	logic [sr_pkg::BYTE_W-1:0] next_store [sr_pkg::NUM_BYTES];
	logic                      next_q;
	logic [sr_pkg::DATA_W-1:0] next_rd_data;
	logic [sr_pkg::BYTE_W-1:0] cur;
	logic [sr_pkg::BYTE_W-1:0] shifted;
	logic                      scan_tick;
	sr_pkg::sr_in_s            in_s;

	sr_scan u_scan (
		.ref_clk (ref_clk),
		.rst     (rst),
		.run     (cfg.run),
		.period  (scan_period),
		.tick    (scan_tick)
	);

	// level inputs, strobe and clear share the scan sample point; power loss is sampled every clock
	sr_edge u_data (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (data_pin),
		.sample  (scan_tick),
		.level   (in_s.data),
		.rise    ()
	);

	sr_edge u_dir (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (dir_pin),
		.sample  (scan_tick),
		.level   (in_s.dir),
		.rise    ()
	);

	sr_edge u_strobe (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (strobe_pin),
		.sample  (scan_tick),
		.level   (),
		.rise    (in_s.strobe_rise)
	);

	sr_edge u_clear (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (clear_pin),
		.sample  (scan_tick),
		.level   (),
		.rise    (in_s.clear_rise)
	);

	// power loss must be seen even while scanning is halted
	sr_edge u_loss (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin     (power_lost_pin),
		.sample  (1'b1),
		.level   (),
		.rise    (in_s.loss_rise)
	);

	// register port: configuration writes
	always_comb begin
		next_cfg = cfg;
		next_scan_period = scan_period;
		if (wr_en) begin
			case (addr)
				sr_pkg::OFF_CTRL: begin
					next_cfg.byte_idx =
						wr_data[sr_pkg::CTRL_BYTE_MSB:sr_pkg::CTRL_BYTE_LSB];
					next_cfg.out_sel =
						wr_data[sr_pkg::CTRL_SEL_MSB:sr_pkg::CTRL_SEL_LSB];
					next_cfg.retain = wr_data[sr_pkg::CTRL_RETAIN];
					next_cfg.run = wr_data[sr_pkg::CTRL_RUN];
				end
				sr_pkg::OFF_SCAN: begin
					next_scan_period = wr_data[sr_pkg::SCAN_W-1:0];
				end
				default: begin
					next_cfg = cfg;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg <= sr_pkg::CTRL_RST;
			scan_period <= sr_pkg::SCAN_RST;
		end else begin
			cfg <= next_cfg;
			scan_period <= next_scan_period;
		end
	end

	// shift datapath on the selected byte
	always_comb begin
		cur = store[cfg.byte_idx];
		if (in_s.dir) begin
			shifted = {in_s.data, cur[7:1]};
		end else begin
			shifted = {cur[6:0], in_s.data};
		end
		for (int i = 0; i < sr_pkg::NUM_BYTES; i++) begin
			next_store[i] = store[i];
		end
		if (in_s.clear_rise) begin
			next_store[cfg.byte_idx] = sr_pkg::BYTE_RST;
		end else if (in_s.strobe_rise) begin
			next_store[cfg.byte_idx] = shifted;
		end
		// whole byte kept when retaining, never part of it
		if (in_s.loss_rise && !cfg.retain) begin
			next_store[cfg.byte_idx] = sr_pkg::BYTE_RST;
		end
		next_q = store[cfg.byte_idx][cfg.out_sel];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int i = 0; i < sr_pkg::NUM_BYTES; i++) begin
				store[i] <= sr_pkg::BYTE_RST;
			end
			q_out <= 1'b0;
		end else begin
			for (int i = 0; i < sr_pkg::NUM_BYTES; i++) begin
				store[i] <= next_store[i];
			end
			q_out <= next_q;
		end
	end

	// register port: read data valid only in the cycle after rd_en
	always_comb begin
		next_rd_data = sr_pkg::READ_IDLE;
		if (rd_en) begin
			case (addr)
				sr_pkg::OFF_CTRL: begin
					next_rd_data[sr_pkg::CTRL_BYTE_MSB:sr_pkg::CTRL_BYTE_LSB] =
						cfg.byte_idx;
					next_rd_data[sr_pkg::CTRL_SEL_MSB:sr_pkg::CTRL_SEL_LSB] =
						cfg.out_sel;
					next_rd_data[sr_pkg::CTRL_RETAIN] = cfg.retain;
					next_rd_data[sr_pkg::CTRL_RUN] = cfg.run;
				end
				sr_pkg::OFF_STATUS: begin
					next_rd_data[sr_pkg::STAT_BYTE_MSB:sr_pkg::STAT_BYTE_LSB] =
						cur;
					next_rd_data[sr_pkg::STAT_OUT] = q_out;
				end
				sr_pkg::OFF_STORE: begin
					next_rd_data = {store[3], store[2], store[1], store[0]};
				end
				sr_pkg::OFF_SCAN: begin
					next_rd_data[sr_pkg::SCAN_W-1:0] = scan_period;
				end
				default: begin
					next_rd_data = sr_pkg::READ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data <= sr_pkg::READ_IDLE;
		end else begin
			rd_data <= next_rd_data;
		end
	end
endmodule
`default_nettype wire

// File: sim/sr_nbr.sv
// neighbour logic model driving the block's input pins
`timescale 1ns/1ns
`default_nettype none
module sr_nbr (
	input  wire logic ref_clk,
	output logic      data_pin,
	output logic      strobe_pin,
	output logic      dir_pin,
	output logic      clear_pin
);
	initial begin
		data_pin = 1'b0;
		strobe_pin = 1'b0;
		dir_pin = 1'b0;
		clear_pin = 1'b0;
	end
	// pins held long enough for sync plus one scan
	task automatic op(input logic b, input logic d, input logic s,
		input logic c);
		@(posedge ref_clk);
		data_pin <= b;
		dir_pin <= d;
		strobe_pin <= s;
		clear_pin <= c;
		repeat (6) @(posedge ref_clk);
		strobe_pin <= 1'b0;
		clear_pin <= 1'b0;
		data_pin <= ~b;
		repeat (6) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

// File: sim/sr_top_assertions.sv
// port assertions for the shift register block
`timescale 1ns/1ns
`default_nettype none
module sr_chk (
	input wire logic                      ref_clk,
	input wire logic                      rst,
	input wire logic                      strobe_pin,
	input wire logic                      clear_pin,
	input wire logic                      power_lost_pin,
	input wire logic [sr_pkg::ADDR_W-1:0] addr,
	input wire logic [sr_pkg::DATA_W-1:0] wr_data,
	input wire logic                      wr_en,
	input wire logic                      rd_en,
	input wire logic [sr_pkg::DATA_W-1:0] rd_data,
	input wire logic                      q_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_rd_idle: assert property (!rd_en |=> rd_data == '0)
		else $error("read data not idle");
	chk_rst_quiet: assert property (disable iff (1'b0)
		rst |=> q_out == 1'b0 && rd_data == '0) else $error("reset outputs");
	chk_unmapped_zero: assert property (rd_en && addr[1:0] != 2'h0
		|=> rd_data == '0) else $error("unmapped read");
	chk_ctrl_upper: assert property (rd_en && addr == sr_pkg::OFF_CTRL
		|=> rd_data[31:7] == '0) else $error("control upper bits");
	chk_stat_upper: assert property (rd_en && addr == sr_pkg::OFF_STATUS
		|=> rd_data[31:9] == '0) else $error("status upper bits");
	chk_scan_rw: assert property (wr_en && addr == sr_pkg::OFF_SCAN ##1
		rd_en && addr == sr_pkg::OFF_SCAN
		|=> rd_data[15:0] == $past(wr_data[15:0], 2)) else $error("scan rw");
	chk_quiet_hold: assert property ((!wr_en && $stable(strobe_pin) &&
		$stable(clear_pin) && $stable(power_lost_pin))[*6]
		|=> $stable(q_out)) else $error("output moved without cause");
	chk_clear_zero: assert property (($rose(clear_pin) ##1
		(!wr_en && !$rose(strobe_pin))[*6]) |=> q_out == 1'b0)
		else $error("clear left a one");
endmodule
bind sr_top sr_chk u_chk (.ref_clk, .rst, .strobe_pin, .clear_pin,
	.power_lost_pin, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .q_out);
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the shift register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        data_pin, strobe_pin, dir_pin, clear_pin;
	logic        power_lost_pin = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wr_data = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [31:0] rd_data, r, cw;
	logic        q_out, ret;
	logic [31:0] seed = 32'hA;
	logic [7:0]  ex [4];
	logic [1:0]  idx;
	logic [2:0]  sel;
	int          n_errors = 0;
	int          comparisons = 0;
	always #2 ref_clk = ~ref_clk;
	sr_nbr nbr (.ref_clk, .data_pin, .strobe_pin, .dir_pin, .clear_pin);
	sr_top dut (.ref_clk, .rst, .data_pin, .strobe_pin, .dir_pin,
		.clear_pin, .power_lost_pin, .addr, .wr_data, .wr_en, .rd_en,
		.rd_data, .q_out);
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] shf(logic [7:0] b, logic v, logic d);
		return d ? {v, b[7:1]} : {b[6:0], v};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, e);
	endtask
	// write, then read the same place with no gap
	task automatic wrd(input logic [3:0] a, input logic [31:0] d,
		input logic [31:0] e);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data, e);
	endtask
	task automatic final_report();
		if (n_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#40000;
		n_errors++;
		final_report();
	end
	initial begin
		foreach (ex[k]) ex[k] = 8'h00;
		{idx, sel, ret} = 6'h00;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rd(sr_pkg::OFF_CTRL, 32'h0000_0040);
		rd(sr_pkg::OFF_STORE, 32'h0000_0000);
		wrd(sr_pkg::OFF_SCAN, 32'h0000_00A5, 32'h0000_00A5);
		wrd(sr_pkg::OFF_SCAN, 32'h0000_0000, 32'h0000_0000);
		rd(4'h2, 32'h0000_0000);
		// scanning halted: strobe edges go unseen
		wrd(sr_pkg::OFF_CTRL, 32'h0000_0000, 32'h0000_0000);
		nbr.op(1'b1, 1'b0, 1'b1, 1'b0);
		rd(sr_pkg::OFF_STORE, 32'h0000_0000);
		wrd(sr_pkg::OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
		for (int i = 0; i < 70; i++) begin
			r = xs();
			case (r[3:0])
				4'h0, 4'h1: begin
					{ret, sel, idx} = r[9:4];
					cw = {25'h0, 1'b1, ret, sel, idx};
					wrd(sr_pkg::OFF_CTRL, cw, cw);
					wrd(sr_pkg::OFF_STATUS, r, {23'h0, ex[idx][sel], ex[idx]});
				end
				4'h2: begin
					nbr.op(r[4], r[5], 1'b0, 1'b1);
					ex[idx] = 8'h00;
				end
				4'h3: begin
					nbr.op(r[4], r[5], 1'b1, 1'b1);
					ex[idx] = 8'h00;
				end
				4'h4: begin
					@(posedge ref_clk);
					power_lost_pin <= 1'b1;
					repeat (3) @(posedge ref_clk);
					power_lost_pin <= 1'b0;
					repeat (3) @(posedge ref_clk);
					if (!ret) ex[idx] = 8'h00;
				end
				default: begin
					nbr.op(r[4], r[5], 1'b1, 1'b0);
					ex[idx] = shf(ex[idx], r[4], r[5]);
				end
			endcase
			rd(sr_pkg::OFF_STORE, {ex[3], ex[2], ex[1], ex[0]});
			rd(sr_pkg::OFF_STATUS, {23'h0, ex[idx][sel], ex[idx]});
			chk({31'h0, q_out}, {31'h0, ex[idx][sel]});
		end
		// reset in mid-run brings back the power-up state
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (ex[k]) ex[k] = 8'h00;
		{idx, sel, ret} = 6'h00;
		rd(sr_pkg::OFF_CTRL, 32'h0000_0040);
		rd(sr_pkg::OFF_STORE, 32'h0000_0000);
		chk({31'h0, q_out}, 32'h0000_0000);
		final_report();
	end
endmodule
`default_nettype wire
